// ---- core/star_coupler_config_register.v ----
`default_nettype none
`include "star_cfg_defines.vh"
module star_coupler_config_register #(
    parameter STAT_W = 12
) (
    input wire core_clk,
    input wire nrst,
    input wire sclk,
    input wire scsn,
    input wire sdi,
    output reg sdo,
    input wire [1:0] branch_tx_error_flag,
    input wire [1:0] branch_forwarding,
    input wire [1:0] branch_bus_raw,
    input wire [1:0] branch_wakeup_raw,
    input wire tx_enable_stuck_flag,
    input wire star_link_stuck_flag,
    input wire [1:0] branch_stuck_flag,
    input wire [STAT_W-1:0] gen_status_live,
    input wire [STAT_W-1:0] br1_status_live,
    input wire [STAT_W-1:0] br2_status_live,
    output reg [1:0] branch_quiet_state,
    output reg [1:0] bus_error_filtered,
    output reg [1:0] branch_wakeup_det,
    output reg controller_port_en,
    output reg rxd_driver_en,
    output reg star_link_port_en,
    output reg stuck_line_irq_flag,
    input wire stuck_irq_clear
);
// ------------------------------------------------------------
// Helpers
// ------------------------------------------------------------
localparam [15:0] FILT_CYC = `FILTER_NS / `CLK_NS;
localparam S_IDLE = 2'b01;
localparam S_SHIFT = 2'b10;
function odd_par;
    input [10:0] v;
    begin
        odd_par = ~(^v);
    end
endfunction
// ------------------------------------------------------------
// Synchronisers for pin inputs
// ------------------------------------------------------------
reg [2:0] s1_q, s2_q, s3_q;
reg [1:0] bus1_q, bus2_q;
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        // Idle levels: select high, clock low, so no false edge after reset
        s1_q <= 3'h4;
        s2_q <= 3'h4;
        s3_q <= 3'h4;
        bus1_q <= 2'h0;
        bus2_q <= 2'h0;
    end else begin
        s1_q <= {scsn, sclk, sdi};
        s2_q <= s1_q;
        s3_q <= s2_q;
        bus1_q <= branch_bus_raw;
        bus2_q <= bus1_q;
    end
end
wire cs_n = s2_q[2];
wire sclk_rise = s2_q[1] & ~s3_q[1];
wire sclk_fall = ~s2_q[1] & s3_q[1];
wire cs_end = cs_n & ~s3_q[2];
// ------------------------------------------------------------
// SPI slave frame engine
// ------------------------------------------------------------
reg [1:0] st_q;
reg [4:0] cnt_q;
reg [15:0] rx_q;
reg [15:0] tx_q;
reg [11:0] cfg_q;
reg [STAT_W-1:0] gen_hold_q, br1_hold_q, br2_hold_q;
reg [2:0] held_q;
reg [2:0] rd_done_q;
wire [11:0] cfg_rd = {cfg_q[11:1], odd_par(cfg_q[11:1])};
reg [11:0] rd_word;
// Read data mux; held copies when holding is on
always @* begin
    case (rx_q[2:0])
        `ADDR_CFG: rd_word = cfg_rd;
        `ADDR_GEN: rd_word = cfg_q[`CFG_HOLD] ? gen_hold_q : gen_status_live;
        `ADDR_BR1: rd_word = cfg_q[`CFG_HOLD] ? br1_hold_q : br1_status_live;
        `ADDR_BR2: rd_word = cfg_q[`CFG_HOLD] ? br2_hold_q : br2_status_live;
        default: rd_word = 12'h000;
    endcase
end
// Sample on falling edge, shift on rising, MSB first
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        st_q <= S_IDLE;
        cnt_q <= 5'h00;
        rx_q <= 16'h0000;
        tx_q <= 16'h0000;
        sdo <= 1'b0;
        cfg_q <= `CFG_RESET;
        rd_done_q <= 3'h0;
    end else begin
        rd_done_q <= 3'h0;
        case (st_q)
            S_IDLE: begin
                cnt_q <= 5'h00;
                if (!cs_n) begin
                    st_q <= S_SHIFT;
                    tx_q <= 16'h0000;
                    sdo <= 1'b0;
                end
            end
            S_SHIFT: begin
                if (sclk_fall && cnt_q < 5'h10) begin
                    rx_q <= {rx_q[14:0], s2_q[0]};
                    cnt_q <= cnt_q + 5'h01;
                    // Config word loaded here is overwritten by the clear below; rd_word loads on the next rise
                    if (cnt_q == 5'h02)
                        tx_q <= {1'b0, cfg_rd, 3'h0} | 16'h0000;
                end
                if (sclk_fall && cnt_q == 5'h02)
                    tx_q <= {4'h0, 12'h000};
                if (sclk_rise && cnt_q == 5'h03) begin
                    tx_q <= {rd_word, 4'h0};
                    sdo <= rd_word[11];
                end else if (sclk_rise && cnt_q > 5'h03) begin
                    sdo <= tx_q[14];
                    tx_q <= {tx_q[14:0], 1'b0};
                end else if (sclk_rise)
                    sdo <= 1'b0;
                if (cs_end) begin
                    st_q <= S_IDLE;
                    sdo <= 1'b0;
                    // Short frames are discarded; long frames keep their first 16 bits
                    if (cnt_q == 5'h10) begin
                        if (rx_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_CFG && !rx_q[`RO_BIT])
                            cfg_q <= rx_q[11:0] & `CFG_WMASK;
                        case (rx_q[`ADDR_MSB:`ADDR_LSB])
                            `ADDR_GEN: rd_done_q <= 3'h1;
                            `ADDR_BR1: rd_done_q <= 3'h2;
                            `ADDR_BR2: rd_done_q <= 3'h4;
                            default: rd_done_q <= 3'h0;
                        endcase
                    end
                end
            end
            default: st_q <= S_IDLE;
        endcase
    end
end
// ------------------------------------------------------------
// Status holding: capture, then release on read
// ------------------------------------------------------------
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        held_q <= 3'h0;
        gen_hold_q <= {STAT_W{1'b0}};
        br1_hold_q <= {STAT_W{1'b0}};
        br2_hold_q <= {STAT_W{1'b0}};
    end else begin
        // Frozen while held; read lets them follow live again
        if (!held_q[0] || rd_done_q[0] || !cfg_q[`CFG_HOLD])
            gen_hold_q <= gen_status_live;
        if (!held_q[1] || rd_done_q[1] || !cfg_q[`CFG_HOLD])
            br1_hold_q <= br1_status_live;
        if (!held_q[2] || rd_done_q[2] || !cfg_q[`CFG_HOLD])
            br2_hold_q <= br2_status_live;
        held_q[0] <= cfg_q[`CFG_HOLD] & (|gen_status_live) & ~rd_done_q[0];
        held_q[1] <= cfg_q[`CFG_HOLD] & (|br1_status_live) & ~rd_done_q[1];
        held_q[2] <= cfg_q[`CFG_HOLD] & (|br2_status_live) & ~rd_done_q[2];
    end
end
// ------------------------------------------------------------
// Bus failure filter per branch
// ------------------------------------------------------------
reg [15:0] filt_cnt_q [0:1];
integer i;
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        filt_cnt_q[0] <= 16'h0000;
        filt_cnt_q[1] <= 16'h0000;
        bus_error_filtered <= 2'h0;
    end else begin
        for (i = 0; i < 2; i = i + 1) begin
            if (!cfg_q[`CFG_BFT]) begin
                bus_error_filtered[i] <= bus2_q[i];
                filt_cnt_q[i] <= 16'h0000;
            end else if (!bus2_q[i]) begin
                bus_error_filtered[i] <= 1'b0;
                filt_cnt_q[i] <= 16'h0000;
            end else if (filt_cnt_q[i] >= FILT_CYC - 16'h0001) begin
                bus_error_filtered[i] <= 1'b1;
            end else
                filt_cnt_q[i] <= filt_cnt_q[i] + 16'h0001;
        end
    end
end
// ------------------------------------------------------------
// Enables, quiet state and stuck-line flag
// ------------------------------------------------------------
wire stuck_any = tx_enable_stuck_flag | star_link_stuck_flag | (|branch_stuck_flag);
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        branch_quiet_state <= 2'h0;
        branch_wakeup_det <= 2'h0;
        controller_port_en <= 1'b0;
        rxd_driver_en <= 1'b0;
        star_link_port_en <= 1'b1;
        stuck_line_irq_flag <= 1'b0;
    end else begin
        branch_quiet_state <= {2{cfg_q[`CFG_AEC]}} & branch_forwarding
                              & branch_tx_error_flag;
        branch_wakeup_det <= branch_wakeup_raw
                             & {cfg_q[`CFG_WUD2], cfg_q[`CFG_WUD1]};
        controller_port_en <= cfg_q[`CFG_CC];
        rxd_driver_en <= cfg_q[`CFG_CC];
        star_link_port_en <= cfg_q[`CFG_LINK];
        // Set beats clear in the same cycle
        if (cfg_q[`CFG_STUCK] && stuck_any)
            stuck_line_irq_flag <= 1'b1;
        else if (stuck_irq_clear)
            stuck_line_irq_flag <= 1'b0;
    end
end
endmodule // star_coupler_config_register
`default_nettype wire

// ---- core/star_cfg_defines.vh ----
// Behaviour
// - Bit 11 enables autonomous error confinement, reset value 0.
// - With confinement on, transmit error in forwarding makes that branch quiet.
// - Bit 10 enables bus failure filter, reset 1; short pulses ignored.
// - Bits 9 and 8 enable wake-up detection on branch 1 and 2, reset 1.
// - Bit 5 enables controller port, reset 0; receive driver off while 0.
// - Bit 4 enables both star link ports, reset 1.
// - Bit 2 enables stuck-line detection on tx enable, link and branches, reset 1.
// - With detection on, any stuck condition raises the stuck-line interrupt flag.
// - Bit 1 enables status holding, reset 0; held until status register read; the code also releases the hold when live status returns to zero.
// - With holding off, status bits show live condition.
// - Bit 0 is read-only odd parity over the word.
// - Frames are 16 bits, MSB first, bits 15:13 hold the address.
// - Bit 12 clear writes bits 11:0; set means read only.
// - Configuration register has address 111.
`ifndef STAR_CFG_DEFINES_VH
`define STAR_CFG_DEFINES_VH
`define FRAME_BITS 16
`define ADDR_MSB 15
`define ADDR_LSB 13
`define RO_BIT 12
`define ADDR_CFG 3'h7
`define ADDR_GEN 3'h2
`define ADDR_BR1 3'h3
`define ADDR_BR2 3'h4
`define CFG_AEC 11
`define CFG_BFT 10
`define CFG_WUD1 9
`define CFG_WUD2 8
`define CFG_CC 5
`define CFG_LINK 4
`define CFG_STUCK 2
`define CFG_HOLD 1
`define CFG_RESET 12'h714
`define CFG_WMASK 12'hF36
`define FILTER_NS 3000
`define CLK_NS 100
`endif

// ---- testbench/cfg_reg_monitor.sv ----
`default_nettype none
module cfg_reg_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic scsn,
    input wire logic sdo,
    input wire logic [1:0] branch_tx_error_flag,
    input wire logic [1:0] branch_forwarding,
    input wire logic [1:0] branch_wakeup_raw,
    input wire logic [1:0] branch_quiet_state,
    input wire logic [1:0] branch_wakeup_det,
    input wire logic controller_port_en,
    input wire logic rxd_driver_en,
    input wire logic star_link_port_en,
    input wire logic stuck_line_irq_flag,
    input wire logic stuck_irq_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Port relations
    // ------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_quiet_cause: assert property ((branch_quiet_state &
        ~$past(branch_forwarding & branch_tx_error_flag)) == 2'h0) else $error("quiet no cause");
    a_rxd_follows_cc: assert property (rxd_driver_en == controller_port_en)
        else $error("rxd driver mismatch");
    // Raw wake input may pass a synchroniser, so allow three cycles
    a_wake_cause: assert property ((branch_wakeup_det & ~($past(branch_wakeup_raw) |
        $past(branch_wakeup_raw, 2) | $past(branch_wakeup_raw, 3))) == 2'h0)
        else $error("wake without input");
    a_reset_values: assert property ($rose(nrst) |-> star_link_port_en
        && !controller_port_en) else $error("reset enables wrong");
    a_cfg_framed: assert property ($changed({controller_port_en, star_link_port_en})
        |-> $past(scsn, 3)) else $error("enable changed inside frame");
    a_link_steady: assert property ($changed(star_link_port_en)
        |=> $stable(star_link_port_en)[*8]) else $error("link enable glitch");
    a_sdo_steady: assert property (!scsn && !sclk && $past(!sclk, 2) && $past(sclk, 3)
        |-> $stable(sdo)) else $error("sdo moved in low phase");
    a_irq_sticky: assert property ($past(stuck_line_irq_flag) && !$past(stuck_irq_clear)
        |-> stuck_line_irq_flag) else $error("stuck flag dropped");
endmodule // cfg_reg_monitor
`default_nettype wire

// ---- testbench/spi_host_model.sv ----
`default_nettype none
module spi_host_model (
    input wire logic core_clk,
    input wire logic sdo,
    output var logic sclk,
    output var logic scsn,
    output var logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Host side of the serial frame
    // ------------------------------------------------
    initial begin
        sclk = 1'b0;
        scsn = 1'b1;
        sdi = 1'b0;
    end
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Top n bits of w, MSB first; r gathers sdo before each fall
    task xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        scsn = 1'b0;
        tick(4);
        for (int i = 15; i > 15 - n; i--) begin
            sdi = w[i];
            sclk = 1'b1;
            tick(4);
            r = {r[14:0], sdo};
            sclk = 1'b0;
            tick(4);
        end
        scsn = 1'b1;
        sdi = ~sdi; // Idle line shows no stale bit
        tick(8);
    endtask
endmodule // spi_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, scsn, sdi, sdo, cc, rxe, lnk, irq;
    logic clr = 1'b0, txs = 1'b0, lks = 1'b0;
    logic [1:0] err = 2'h0, fwd = 2'h0, bus = 2'h0, wak = 2'h0, bst = 2'h0;
    logic [1:0] quiet, filt, wdet;
    logic [11:0] gs = 12'h000;
    logic [15:0] s = 16'h0865, r;
    logic [11:1] c = 11'h38A;
    int n_errors = 0, n_checks = 0, cyc = 0;
    // ------------------------------------------------
    // Device, host and helpers
    // ------------------------------------------------
    star_coupler_config_register u_star_coupler_config_register (.core_clk, .nrst,
        .sclk, .scsn, .sdi, .sdo, .branch_tx_error_flag(err), .branch_forwarding(fwd),
        .branch_bus_raw(bus), .branch_wakeup_raw(wak), .tx_enable_stuck_flag(txs),
        .star_link_stuck_flag(lks), .branch_stuck_flag(bst), .gen_status_live(gs),
        .br1_status_live(~gs), .br2_status_live(gs ^ s[11:0]), .branch_quiet_state(quiet),
        .bus_error_filtered(filt), .branch_wakeup_det(wdet), .controller_port_en(cc),
        .rxd_driver_en(rxe), .star_link_port_en(lnk), .stuck_line_irq_flag(irq),
        .stuck_irq_clear(clr));
    spi_host_model u_spi_host_model (.core_clk, .sdo, .sclk, .scsn, .sdi);
    always #50 core_clk = ~core_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [11:0] word(input logic [11:1] v);
        return {v, ~^v};
    endfunction
    task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task rd;
        u_spi_host_model.xfer({4'hF, s[11:0]}, 16, r);
        chk("cfg", word(c), r[12:1]);
    endtask
    // Long pulse must pass the 30 cycle filter, short only when it is off
    task pulse(input int n);
        logic [1:0] saw;
        saw = 2'h0;
        bus = 2'h3;
        repeat (n) begin
            u_spi_host_model.tick(1);
            saw |= filt;
        end
        bus = 2'h0;
        u_spi_host_model.tick(6);
        chk("filter", 12'((!c[10] || n > 30) ? 2'h3 : 2'h0), 12'(saw | filt));
    endtask
    // Limit on run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 12000) begin
            n_errors++;
            test_done();
        end
    end
    // Main sequence: reset, random writes with corners, refused frames
    initial begin
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        u_spi_host_model.tick(3);
        chk("reset", 12'h001, 12'({cc, 3'h0, lnk}));
        rd();
        for (int i = 0; i < 8; i++) begin
            s = lfsr(lfsr(s));
            u_spi_host_model.xfer({4'hE, i == 0 ? 12'h000 : i == 1 ? 12'hFFF : s[11:0]}, 16, r);
            c = (i == 0 ? 11'h0 : i == 1 ? 11'h7FF : s[11:1]) & 11'h79B;
            rd();
            chk("ports", 12'({c[5], c[5], c[4]}), 12'({cc, rxe, lnk}));
            s = lfsr(s);
            {fwd, err, wak, bst, txs, lks} = s[9:0];
            gs = s[15:4];
            u_spi_host_model.tick(4);
            chk("quiet", 12'({2{c[11]}} & fwd & err), 12'(quiet));
            chk("wake", 12'(wak & {c[8], c[9]}), 12'(wdet));
            chk("stuck", 12'(c[2] & |{bst, txs, lks}), 12'(irq));
            {bst, txs, lks} = 4'h0;
            clr = 1'b1;
            pulse(12);
            pulse(40);
            clr = 1'b0;
        end
        // Status reads: live with holding off, captured then released with it on
        gs = 12'h5A3;
        c[1] = 1'b0;
        u_spi_host_model.xfer({4'hE, word(c)}, 16, r);
        u_spi_host_model.xfer(16'h5000, 16, r);
        chk("live", 12'h5A3, r[12:1]);
        c[1] = 1'b1;
        u_spi_host_model.xfer({4'hE, word(c)}, 16, r);
        u_spi_host_model.tick(4);
        gs = 12'h0C6;
        u_spi_host_model.xfer(16'h5000, 16, r);
        chk("held", 12'h5A3, r[12:1]);
        u_spi_host_model.xfer(16'h5000, 16, r);
        chk("release", 12'h0C6, r[12:1]);
        u_spi_host_model.xfer({4'hE, ~c, 1'b0}, 15, r);
        u_spi_host_model.xfer({4'h0, ~c, 1'b0}, 16, r);
        rd();
        test_done();
    end
endmodule // tb_top
bind star_coupler_config_register cfg_reg_monitor u_cfg_reg_monitor (.core_clk, .nrst,
    .sclk, .scsn, .sdo, .branch_tx_error_flag, .branch_forwarding, .branch_wakeup_raw,
    .branch_quiet_state, .branch_wakeup_det, .controller_port_en, .rxd_driver_en,
    .star_link_port_en, .stuck_line_irq_flag, .stuck_irq_clear);
`default_nettype wire
